/* File: src/rhp_root_port_ctrl.sv */
`include "rhp_consts.svh"

// Power, reset, overcurrent and resume control of two root hub ports.
module rhp_root_port_ctrl #(
	parameter int unsigned RESET_CYC  = `RHP_RESET_CYC,
	parameter int unsigned RESUME_CYC = `RHP_RESUME_CYC,
	parameter int unsigned RESYNC_CYC = `RHP_RESYNC_CYC
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt.
	output logic             irq,
	// Port pins.
	input  wire logic [1:0]  port_overcurrent,
	output logic [1:0]       port_power_en,
	output logic [1:0]       port_reset_drive,
	output logic [1:0]       port_resume_drive,
	// Neighbouring status logic.
	input  wire logic [1:0]  device_connected_flag,
	input  wire logic [1:0]  port_enabled_flag,
	input  wire logic [1:0]  port_suspended_flag,
	input  wire logic [1:0]  low_speed_attached,
	input  wire logic [1:0]  connect_event,
	output logic [1:0]       port_status_clear,
	output logic [1:0]       reset_complete,
	output logic [1:0]       resume_complete
);
	rhp_pkg::rhp_state_type st_reg;  // Registered state.
	rhp_pkg::rhp_state_type st_next; // Next state.

	// Per-port wires to and from the timers.
	logic [1:0] start_reset;  // Begin reset signalling.
	logic [1:0] start_resume; // Begin the resume sequence.
	logic [1:0] tmr_abort;    // Stop any sequence at power loss.
	logic [1:0] rst_active;   // Reset signalling on the wire.
	logic [1:0] rsm_active;   // Resume pulse on the wire.
	logic [1:0] rst_done;     // Reset interval finished.
	logic [1:0] rsm_done;     // Resume sequence finished.

	// Bus phase decode.
	logic       bus_setup;    // First cycle of a transfer.
	logic       bus_wr;       // Write taking effect this edge.
	logic       mapped;       // Address hits a register.
	logic [31:0] rd_word;     // Read value of the addressed word.

	// Decoded write strobes.
	logic       glob_on;      // Global power on, for ports not selected per port.
	logic       glob_off;     // Global power off, for ports not selected per port.
	logic [1:0] port_wr;      // Write to a port word.
	logic [1:0] on_ok;        // Honoured power on command.
	logic [1:0] off_ok;       // Honoured power off command.
	logic [1:0] power_drop;   // Power falls this edge.
	logic [1:0] oc_seen;      // Overcurrent as reported.
	logic [31:0] pword [2];   // Port read words.

	// Mode bits from the control word.
	logic       scheme;       // 0 global, 1 per port.
	logic [1:0] sel;          // Per-port command select.
	logic       nosw;         // Power switching absent.
	logic       ocrep;        // Per-port overcurrent reporting.

	assign scheme = st_reg.ctrl[`RHP_C_SCHEME];
	assign sel    = st_reg.ctrl[`RHP_C_SEL +: 2];
	assign nosw   = st_reg.ctrl[`RHP_C_NOSW];
	assign ocrep  = st_reg.ctrl[`RHP_C_OCREP];

	// The slave answers with no wait states; the read word is captured in setup.
	assign bus_setup = psel & ~penable;
	assign bus_wr    = psel & penable & pwrite;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~mapped;
	assign prdata    = st_reg.rdata;

	// Interrupt is a level from the status and mask flops.
	assign irq = |(st_reg.istat & st_reg.imask);

	// Global commands share one write-only word.
	assign glob_on  = bus_wr & (paddr == `RHP_OFF_GLOBAL) & pwdata[`RHP_G_ON];
	assign glob_off = bus_wr & (paddr == `RHP_OFF_GLOBAL) & pwdata[`RHP_G_OFF];
	assign port_wr[0] = bus_wr & (paddr == `RHP_OFF_PORT1);
	assign port_wr[1] = bus_wr & (paddr == `RHP_OFF_PORT2);

	// Every property below runs on the bus clock and is off during reset.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	for (genvar i = 0; i < 2; i++)
	begin : g_port
		rhp_timer_if tif ();

		assign tif.start_reset  = start_reset[i];
		assign tif.start_resume = start_resume[i];
		assign tif.abort        = tmr_abort[i];
		assign rst_active[i]    = tif.reset_active;
		assign rsm_active[i]    = tif.resume_active;
		assign rst_done[i]      = tif.reset_done;
		assign rsm_done[i]      = tif.resume_done;

		rhp_port_timer #(
			.RESET_CYC  (RESET_CYC),
			.RESUME_CYC (RESUME_CYC),
			.RESYNC_CYC (RESYNC_CYC)
		) u_tmr (
			.pclk    (pclk),
			.presetn (presetn),
			.t       (tif.tmr)
		);

		// per-port mode, select bit picks the command kind.
		assign on_ok[i]  = (scheme & sel[i]) ? (port_wr[i] & pwdata[`RHP_B_PPS]) : glob_on;
		assign off_ok[i] = (scheme & sel[i]) ? (port_wr[i] & pwdata[`RHP_B_POFF]) : glob_off;
		assign oc_seen[i] = ocrep & port_overcurrent[i];

		// Pins; the power enable is forced on when switching is absent.
		assign port_power_en[i]     = st_reg.prt[i].port_power_on_flag | nosw;
		assign port_reset_drive[i]  = rst_active[i];
		assign port_resume_drive[i] = rsm_active[i];
		assign port_status_clear[i] = st_reg.prt[i].clr_pulse;
		assign reset_complete[i]    = rst_done[i];
		assign resume_complete[i]   = rsm_done[i];

		chk_oc_drops_power: assert property (
			port_overcurrent[i] |=> !st_reg.prt[i].port_power_on_flag)
			else $error("power kept under overcurrent");
		chk_global_mode_only: assert property (
			(!scheme && port_wr[i] && pwdata[`RHP_B_PPS] && !glob_on
				&& !st_reg.prt[i].port_power_on_flag) |=> !st_reg.prt[i].port_power_on_flag)
			else $error("port command acted in global mode");
		chk_select_ignores_global: assert property (
			(scheme && sel[i] && glob_on && !(port_wr[i] && pwdata[`RHP_B_PPS])
				&& !st_reg.prt[i].port_power_on_flag) |=> !st_reg.prt[i].port_power_on_flag)
			else $error("global command reached selected port");
		chk_off_clears_status: assert property (
			(st_reg.prt[i].port_power_on_flag && off_ok[i] && !on_ok[i])
				|=> !st_reg.prt[i].port_power_on_flag && !st_reg.prt[i].port_reset_active_flag
				&& st_reg.prt[i].clr_pulse ##1 !st_reg.prt[i].clr_pulse)
			else $error("power off left status set");
		chk_reset_done_clears: assert property (
			$rose(st_reg.prt[i].rdc) && st_reg.prt[i].port_power_on_flag |-> !st_reg.prt[i].port_reset_active_flag
				&& $past(st_reg.prt[i].port_reset_active_flag))
			else $error("reset status not cleared with change flag");
		chk_reset_unconnected: assert property (
			(port_wr[i] && pwdata[`RHP_B_PRS] && !device_connected_flag[i]
				&& !st_reg.prt[i].port_reset_active_flag) |=> !st_reg.prt[i].port_reset_active_flag && st_reg.prt[i].connect_change_flag)
			else $error("reset accepted on empty port");
		chk_oc_read_follows: assert property (
			(bus_setup && paddr == (i == 0 ? `RHP_OFF_PORT1 : `RHP_OFF_PORT2))
				|=> prdata[`RHP_B_PORT_OVERCURRENT_FLAG] == $past(ocrep && port_overcurrent[i]))
			else $error("overcurrent bit does not follow pin");
		chk_resume_needs_suspend: assert property (
			$rose(rsm_active[i]) |-> $past(port_suspended_flag[i], 2))
			else $error("resume started on a running port");
		chk_nosw_reads_one: assert property (
			(bus_setup && nosw && paddr == (i == 0 ? `RHP_OFF_PORT1 : `RHP_OFF_PORT2))
				|=> prdata[`RHP_B_PPS])
			else $error("power bit low without switching");
	end

	// Build the port read words; bits not listed stay zero.
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			pword[i]               = 32'h00000000;
			pword[i][`RHP_B_RDC]   = st_reg.prt[i].rdc;
			pword[i][`RHP_B_RSDC]  = st_reg.prt[i].rsdc;
			pword[i][`RHP_B_CSC]   = st_reg.prt[i].connect_change_flag;
			pword[i][`RHP_B_POFF]  = low_speed_attached[i];
			pword[i][`RHP_B_PPS]   = st_reg.prt[i].port_power_on_flag | nosw;
			pword[i][`RHP_B_PRS]   = st_reg.prt[i].port_reset_active_flag;
			pword[i][`RHP_B_PORT_OVERCURRENT_FLAG]  = oc_seen[i];
			pword[i][`RHP_B_PSS]   = port_suspended_flag[i];
			pword[i][`RHP_B_PES]   = port_enabled_flag[i];
			pword[i][`RHP_B_CCS]   = device_connected_flag[i];
		end
	end

	// Address decode for reads; unmapped addresses read zero and flag an error.
	always_comb
	begin
		mapped  = 1'b1;
		rd_word = 32'h00000000;
		if (paddr == `RHP_OFF_CTRL)
			rd_word[4:0] = st_reg.ctrl;
		else if (paddr == `RHP_OFF_GLOBAL)
			rd_word = 32'h00000000;
		else if (paddr == `RHP_OFF_PORT1)
			rd_word = pword[0];
		else if (paddr == `RHP_OFF_PORT2)
			rd_word = pword[1];
		else if (paddr == `RHP_OFF_ISTAT)
			rd_word[5:0] = st_reg.istat;
		else if (paddr == `RHP_OFF_IMASK)
			rd_word[5:0] = st_reg.imask;
		else
			mapped = 1'b0;
	end

	// Next state of the whole block.
	always_comb
	begin
		st_next      = st_reg;
		start_reset  = 2'b00;
		start_resume = 2'b00;
		tmr_abort    = 2'b00;
		power_drop   = 2'b00;

		// Read data is taken in the setup cycle so it comes from a flop.
		if (bus_setup)
			st_next.rdata = rd_word;

		// Configuration words.
		if (bus_wr && paddr == `RHP_OFF_CTRL)
			st_next.ctrl = pwdata[4:0];
		if (bus_wr && paddr == `RHP_OFF_IMASK)
			st_next.imask = pwdata[5:0];

		// Interrupt status: write one clears, a new event wins over the clear.
		if (bus_wr && paddr == `RHP_OFF_ISTAT)
			st_next.istat = st_reg.istat & ~pwdata[5:0];

		for (int i = 0; i < 2; i++)
		begin
			st_next.prt[i].clr_pulse = 1'b0;

			// honoured commands move power; off write clears it.
			if (off_ok[i])
				st_next.prt[i].port_power_on_flag = 1'b0;
			else if (on_ok[i])
				st_next.prt[i].port_power_on_flag = 1'b1;
			if (port_overcurrent[i])
				st_next.prt[i].port_power_on_flag = 1'b0;
			power_drop[i] = st_reg.prt[i].port_power_on_flag & ~st_next.prt[i].port_power_on_flag;

			// Change flags clear on a written one.
			if (port_wr[i])
			begin
				if (pwdata[`RHP_B_RDC])
					st_next.prt[i].rdc = 1'b0;
				if (pwdata[`RHP_B_RSDC])
					st_next.prt[i].rsdc = 1'b0;
				if (pwdata[`RHP_B_CSC])
					st_next.prt[i].connect_change_flag = 1'b0;
			end

			// reset write; a missing device sets the change flag instead.
			if (port_wr[i] && pwdata[`RHP_B_PRS] && !st_reg.prt[i].port_reset_active_flag)
			begin
				if (!device_connected_flag[i])
					st_next.prt[i].connect_change_flag = 1'b1;
				else if (st_reg.prt[i].port_power_on_flag && !power_drop[i])
				begin
					st_next.prt[i].port_reset_active_flag = 1'b1;
					start_reset[i]     = 1'b1;
				end
			end

			if (port_wr[i] && pwdata[`RHP_B_PORT_OVERCURRENT_FLAG] && port_suspended_flag[i]
				&& !st_reg.prt[i].port_reset_active_flag && !power_drop[i])
				start_resume[i] = 1'b1;

			// Connect events from the neighbouring logic set the change flag.
			if (connect_event[i])
				st_next.prt[i].connect_change_flag = 1'b1;

			if (rsm_done[i])
			begin
				st_next.prt[i].rsdc = 1'b1;
				st_next.istat[2 + i] = 1'b1;
			end

			if (rst_done[i])
			begin
				st_next.prt[i].port_reset_active_flag  = 1'b0;
				st_next.prt[i].rdc  = 1'b1;
				st_next.prt[i].rsdc = 1'b0;
				st_next.istat[i]    = 1'b1;
			end

			if (power_drop[i])
			begin
				st_next.prt[i].port_reset_active_flag       = 1'b0;
				st_next.prt[i].clr_pulse = 1'b1;
				tmr_abort[i]             = 1'b1;
				start_reset[i]           = 1'b0;
				if (port_overcurrent[i])
					st_next.istat[4 + i] = 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg       <= '0;
			st_reg.ctrl  <= `RHP_CTRL_RST;
			st_reg.imask <= `RHP_IRQ_RST;
		end
		else
			st_reg <= st_next;
	end
endmodule : rhp_root_port_ctrl

/* File: shared/rhp_consts.svh */
`ifndef RHP_CONSTS_SVH
`define RHP_CONSTS_SVH

// Clock rate and documented intervals.
`define RHP_CLK_MHZ     250
`define RHP_RESET_MS    10
`define RHP_RESUME_MS   20
`define RHP_RESYNC_MS   3
`define RHP_EOP_NS      1333
`define RHP_RESET_CYC   (`RHP_RESET_MS * `RHP_CLK_MHZ * 1000)
`define RHP_RESUME_CYC  (`RHP_RESUME_MS * `RHP_CLK_MHZ * 1000)
`define RHP_RESYNC_CYC  (`RHP_RESYNC_MS * `RHP_CLK_MHZ * 1000)
`define RHP_EOP_CYC     ((`RHP_EOP_NS * `RHP_CLK_MHZ + 999) / 1000)
`define RHP_CNT_W       23

// Register byte offsets.
`define RHP_OFF_CTRL    12'h000
`define RHP_OFF_GLOBAL  12'h004
`define RHP_OFF_PORT1   12'h008
`define RHP_OFF_PORT2   12'h00c
`define RHP_OFF_ISTAT   12'h010
`define RHP_OFF_IMASK   12'h014

// Port status bit positions.
`define RHP_B_RDC       20
`define RHP_B_RSDC      18
`define RHP_B_CSC       16
`define RHP_B_POFF      9
`define RHP_B_PPS       8
`define RHP_B_PRS       4
`define RHP_B_PORT_OVERCURRENT_FLAG      3
`define RHP_B_PSS       2
`define RHP_B_PES       1
`define RHP_B_CCS       0

// Control and global command bit positions.
`define RHP_C_SCHEME    0
`define RHP_C_SEL       1
`define RHP_C_NOSW      3
`define RHP_C_OCREP     4
`define RHP_G_OFF       0
`define RHP_G_ON        1

// Reset values.
`define RHP_CTRL_RST    5'h10
`define RHP_IRQ_RST     6'h00

`endif

/* File: shared/rhp_pkg.sv */
package rhp_pkg;
	// Sequencer states of one port's timer.
	typedef enum logic [2:0] {tmr_idle, tmr_reset, tmr_resume, tmr_eop, tmr_resync} rhp_tmr_state_type;

	// Timer state.
	typedef struct packed {
		rhp_tmr_state_type state;
		logic [22:0]       cnt;
		logic              reset_done;
		logic              resume_done;
	} rhp_tmr_type;

	// Per-port status held by the root port logic.
	typedef struct packed {
		logic port_power_on_flag;
		logic port_reset_active_flag;
		logic connect_change_flag;
		logic rdc;
		logic rsdc;
		logic clr_pulse;
	} rhp_port_type;

	// Whole state of the top module.
	typedef struct packed {
		logic [4:0]              ctrl;
		logic [5:0]              imask;
		logic [5:0]              istat;
		logic [31:0]             rdata;
		rhp_port_type [1:0]      prt;
	} rhp_state_type;
endpackage : rhp_pkg

/* File: shared/rhp_timer_if.sv */
// Link between the port logic and one port's signalling timer.
interface rhp_timer_if;
	logic start_reset;
	logic start_resume;
	logic abort;
	logic reset_active;
	logic resume_active;
	logic reset_done;
	logic resume_done;

	modport ctl (output start_reset, output start_resume, output abort,
		input reset_active, input resume_active, input reset_done, input resume_done);
	modport tmr (input start_reset, input start_resume, input abort,
		output reset_active, output resume_active, output reset_done, output resume_done);
endinterface : rhp_timer_if

/* File: src/rhp_port_timer.sv */
`include "rhp_consts.svh"

// Times port reset signalling and the resume sequence of one port.
module rhp_port_timer #(
	parameter int unsigned RESET_CYC  = `RHP_RESET_CYC,
	parameter int unsigned RESUME_CYC = `RHP_RESUME_CYC,
	parameter int unsigned RESYNC_CYC = `RHP_RESYNC_CYC
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Control link.
	rhp_timer_if.tmr  t
);
	localparam logic [22:0] RST_LAST = 23'(RESET_CYC - 1);
	localparam logic [22:0] RSM_LAST = 23'(RESUME_CYC - 1);
	localparam logic [22:0] EOP_LAST = 23'(`RHP_EOP_CYC - 1);
	localparam logic [22:0] SYN_LAST = 23'(RESYNC_CYC - 1);

	rhp_pkg::rhp_tmr_type st_reg;  // Registered state.
	rhp_pkg::rhp_tmr_type st_next; // Next state.

	// Outputs decode directly from the state flops.
	assign t.reset_active  = (st_reg.state == rhp_pkg::tmr_reset);
	assign t.resume_active = (st_reg.state == rhp_pkg::tmr_resume);
	assign t.reset_done    = st_reg.reset_done;
	assign t.resume_done   = st_reg.resume_done;

	// Sequencer; a start while busy is ignored, abort always wins.
	always_comb
	begin
		st_next             = st_reg;
		st_next.cnt         = st_reg.cnt + 23'h000001;
		st_next.reset_done  = 1'b0;
		st_next.resume_done = 1'b0;
		case (st_reg.state)
			rhp_pkg::tmr_idle:
			begin
				st_next.cnt = 23'h000000;
				if (t.start_reset)
					st_next.state = rhp_pkg::tmr_reset;
				else if (t.start_resume)
					st_next.state = rhp_pkg::tmr_resume;
			end
			rhp_pkg::tmr_reset:
				if (st_reg.cnt == RST_LAST)
				begin
					st_next.state      = rhp_pkg::tmr_idle;
					st_next.reset_done = 1'b1;
				end
			rhp_pkg::tmr_resume:
				if (st_reg.cnt == RSM_LAST)
				begin
					st_next.state = rhp_pkg::tmr_eop;
					st_next.cnt   = 23'h000000;
				end
			rhp_pkg::tmr_eop:
				if (st_reg.cnt == EOP_LAST)
				begin
					st_next.state = rhp_pkg::tmr_resync;
					st_next.cnt   = 23'h000000;
				end
			default:
				if (st_reg.cnt == SYN_LAST)
				begin
					st_next.state       = rhp_pkg::tmr_idle;
					st_next.resume_done = 1'b1;
				end
		endcase
		if (t.abort)
		begin
			st_next.state       = rhp_pkg::tmr_idle;
			st_next.reset_done  = 1'b0;
			st_next.resume_done = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_reset_full_length: assert property (
		$rose(st_reg.reset_done) |-> $past(st_reg.cnt) == RST_LAST)
		else $error("reset ended early");
	chk_resume_after_sync: assert property (
		$rose(st_reg.resume_done) |-> $past(st_reg.state) == rhp_pkg::tmr_resync)
		else $error("resume done before resync");
endmodule : rhp_port_timer

/* File: bench/rhp_dev_model.sv */
// Downstream device on both root ports: connects when the port is powered, gets
// enabled by a finished port reset, and can be put to sleep by the bench.
module rhp_dev_model (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bench controls.
	input  wire logic [1:0] plug,
	input  wire logic [1:0] suspend_req,
	input  wire logic [1:0] oc_req,
	// Port side of the block.
	input  wire logic [1:0] port_power_en,
	input  wire logic [1:0] port_status_clear,
	input  wire logic [1:0] reset_complete,
	input  wire logic [1:0] resume_complete,
	output logic [1:0]      port_overcurrent,
	output logic [1:0]      device_connected_flag,
	output logic [1:0]      port_enabled_flag,
	output logic [1:0]      port_suspended_flag,
	output logic [1:0]      low_speed_attached,
	output logic [1:0]      connect_event
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] conn_reg; // Connection seen one cycle ago, to find changes.

	// A device only shows up while its port has power; port 2 is low speed.
	assign device_connected_flag = plug & port_power_en;
	assign low_speed_attached    = device_connected_flag & 2'b10;
	assign port_overcurrent      = oc_req;

	// Connect changes, enable and suspend state of the attached devices.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conn_reg            <= 2'b00;
			connect_event       <= 2'b00;
			port_enabled_flag   <= 2'b00;
			port_suspended_flag <= 2'b00;
		end
		else
		begin
			conn_reg            <= device_connected_flag;
			connect_event       <= device_connected_flag ^ conn_reg;
			// A power drop wipes enable and suspend, as the neighbour logic would.
			port_enabled_flag   <= (port_enabled_flag | reset_complete) & ~port_status_clear;
			port_suspended_flag <= (port_suspended_flag | (suspend_req & device_connected_flag))
				& ~resume_complete & ~port_status_clear;
		end
	end
endmodule : rhp_dev_model

/* File: bench/testbench.sv */
`include "rhp_consts.svh"

// Self-checking bench of the two-port power, reset and resume control.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// Short timer counts keep the run brief; expectations derive from them.
	localparam int unsigned RST_N = 20;
	localparam int unsigned RSM_N = 30;
	localparam int unsigned SYN_N = 10;
	localparam logic [11:0] CTRL = `RHP_OFF_CTRL;
	localparam logic [11:0] GLB  = `RHP_OFF_GLOBAL;
	localparam logic [11:0] P1   = `RHP_OFF_PORT1;
	localparam logic [11:0] P2   = `RHP_OFF_PORT2;
	localparam logic [11:0] IST  = `RHP_OFF_ISTAT;
	localparam logic [11:0] IMK  = `RHP_OFF_IMASK;
	localparam logic [31:0] PORT_POWER_ON_FLAG  = 32'h0000_0100;
	localparam logic [31:0] POFF = 32'h0000_0200;
	localparam logic [31:0] PORT_RESET_ACTIVE_FLAG  = 32'h0000_0010;
	localparam logic [31:0] PORT_OVERCURRENT_FLAG = 32'h0000_0008;
	localparam logic [31:0] PORT_SUSPENDED_FLAG  = 32'h0000_0004;
	localparam logic [31:0] PORT_ENABLED_FLAG  = 32'h0000_0002;
	localparam logic [31:0] CONNECT_CHANGE_FLAG  = 32'h0001_0000;
	localparam logic [31:0] RSDC = 32'h0004_0000;
	localparam logic [31:0] RDC  = 32'h0010_0000;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0]  oc, pwr_en, rst_drv, rsm_drv, conn, ena, susp, ls, cev, clr, rdone, sdone;
	logic [1:0]  plug, susp_req, oc_req; // Requests to the device model.
	logic [31:0] rd;                     // Word of the last read.
	logic        rd_err;                 // Error answer of the last read.
	int          n_mismatch, n_compared;
	int          cyc, rst_len, rsm_len;  // Watchdog and drive lengths on port 1.

	rhp_root_port_ctrl #(.RESET_CYC(RST_N), .RESUME_CYC(RSM_N), .RESYNC_CYC(SYN_N)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .port_overcurrent(oc), .port_power_en(pwr_en), .port_reset_drive(rst_drv),
		.port_resume_drive(rsm_drv), .device_connected_flag(conn), .port_enabled_flag(ena),
		.port_suspended_flag(susp), .low_speed_attached(ls), .connect_event(cev),
		.port_status_clear(clr), .reset_complete(rdone), .resume_complete(sdone));

	rhp_dev_model dev (
		.pclk(pclk), .presetn(presetn), .plug(plug), .suspend_req(susp_req), .oc_req(oc_req),
		.port_power_en(pwr_en), .port_status_clear(clr), .reset_complete(rdone),
		.resume_complete(sdone), .port_overcurrent(oc), .device_connected_flag(conn),
		.port_enabled_flag(ena), .port_suspended_flag(susp), .low_speed_attached(ls),
		.connect_event(cev));

	// Free-running 250 MHz clock.
	always #2 pclk = ~pclk;

	// Drive lengths are counted here so a wrong interval shows as a number.
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (rst_drv[0] === 1'b1)
			rst_len <= rst_len + 1;
		if (rsm_drv[0] === 1'b1)
			rsm_len <= rsm_len + 1;
		// A hang counts as a mismatch and ends the run.
		if (cyc == 20000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	// Compare one value; every comparison is counted.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd      = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read a word and compare only the bits under the mask.
	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(what, e & m, rd & m);
	endtask : rchk

	// Reset values, reserved bits and an unmapped address.
	task automatic t_reset_vals();
		rchk("ctrl", CTRL, 32'hffff_ffff, 32'h0000_0010);
		rchk("port1 word", P1, 32'hffff_ffff, 32'h0);
		rchk("unmapped", 12'h018, 32'hffff_ffff, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rd_err});
		chk("irq", 32'h0, {31'h0, irq});
	endtask : t_reset_vals

	// Global scheme: per-port power writes do nothing, global ones do.
	task automatic t_global();
		apb(1'b1, P1, PORT_POWER_ON_FLAG);
		rchk("pps port cmd", P1, PORT_POWER_ON_FLAG, 32'h0);
		apb(1'b1, GLB, 32'h2);
		rchk("pps global on", P2, PORT_POWER_ON_FLAG, PORT_POWER_ON_FLAG);
		chk("power en", 32'h3, {30'h0, pwr_en});
		apb(1'b1, P1, POFF);
		rchk("pps port off", P1, PORT_POWER_ON_FLAG, PORT_POWER_ON_FLAG);
	endtask : t_global

	// Reset on a connected port: timed drive, done flag, masked then live irq.
	task automatic t_port_reset();
		rst_len = 0;
		apb(1'b1, P1, PORT_RESET_ACTIVE_FLAG);
		rchk("prs set", P1, PORT_RESET_ACTIVE_FLAG, PORT_RESET_ACTIVE_FLAG);
		for (int i = 0; i < 200 && rdone[0] !== 1'b1; i++)
			@(posedge pclk);
		@(posedge pclk);
		chk("reset length", RST_N, rst_len);
		rchk("reset done", P1, PORT_RESET_ACTIVE_FLAG | RDC | PORT_ENABLED_FLAG, RDC | PORT_ENABLED_FLAG);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, IMK, 32'h3f);
		rchk("istat", IST, 32'h3f, 32'h1);
		chk("irq on", 32'h1, {31'h0, irq});
		apb(1'b1, IST, 32'h3f);
		apb(1'b1, P1, RDC | CONNECT_CHANGE_FLAG);
		rchk("rdc w1c", P1, RDC | CONNECT_CHANGE_FLAG, 32'h0);
		chk("irq off", 32'h0, {31'h0, irq});
	endtask : t_port_reset

	// Reset on a powered but empty port only raises the connect change.
	task automatic t_disc_reset();
		apb(1'b1, P2, PORT_RESET_ACTIVE_FLAG);
		rchk("no prs", P2, PORT_RESET_ACTIVE_FLAG | CONNECT_CHANGE_FLAG, CONNECT_CHANGE_FLAG);
		chk("no drive", 32'h0, {30'h0, rst_drv});
	endtask : t_disc_reset

	// Per-port scheme: port 1 takes port commands, port 2 global ones.
	task automatic t_per_port();
		apb(1'b1, CTRL, 32'h13);
		apb(1'b1, GLB, 32'h1);
		rchk("p1 keeps", P1, PORT_POWER_ON_FLAG, PORT_POWER_ON_FLAG);
		rchk("p2 off", P2, PORT_POWER_ON_FLAG, 32'h0);
		apb(1'b1, P1, POFF);
		rchk("p1 off", P1, PORT_POWER_ON_FLAG | PORT_ENABLED_FLAG, 32'h0);
		chk("power en", 32'h0, {30'h0, pwr_en});
		apb(1'b1, P1, 32'h0);
		rchk("zero write", P1, PORT_POWER_ON_FLAG, 32'h0);
		apb(1'b1, P1, PORT_POWER_ON_FLAG);
		rchk("p1 on", P1, PORT_POWER_ON_FLAG, PORT_POWER_ON_FLAG);
		apb(1'b1, GLB, 32'h2);
		rchk("p2 on", P2, PORT_POWER_ON_FLAG, PORT_POWER_ON_FLAG);
	endtask : t_per_port

	// Overcurrent drops power, is shown live, and hidden when not reported.
	task automatic t_overcurrent();
		oc_req <= 2'b01;
		repeat (3) @(posedge pclk);
		rchk("oc on", P1, PORT_POWER_ON_FLAG | PORT_OVERCURRENT_FLAG, PORT_OVERCURRENT_FLAG);
		rchk("oc event", IST, 32'h10, 32'h10);
		oc_req <= 2'b00;
		rchk("oc gone", P1, PORT_POWER_ON_FLAG | PORT_OVERCURRENT_FLAG, 32'h0);
		apb(1'b1, CTRL, 32'h03);
		oc_req <= 2'b01;
		rchk("oc hidden", P1, PORT_OVERCURRENT_FLAG, 32'h0);
		oc_req <= 2'b00;
		apb(1'b1, CTRL, 32'h13);
		apb(1'b1, P1, PORT_POWER_ON_FLAG);
		apb(1'b1, IST, 32'h3f);
	endtask : t_overcurrent

	// Resume is ignored while awake and runs the full sequence when asleep.
	task automatic t_resume();
		int i;
		apb(1'b1, P1, PORT_OVERCURRENT_FLAG);
		repeat (4) @(posedge pclk);
		chk("no resume", 32'h0, {30'h0, rsm_drv});
		susp_req <= 2'b01;
		@(posedge pclk);
		susp_req <= 2'b00;
		rchk("asleep", P1, PORT_SUSPENDED_FLAG, PORT_SUSPENDED_FLAG);
		rsm_len = 0;
		apb(1'b1, P1, PORT_OVERCURRENT_FLAG);
		for (i = 0; i < 1000 && sdone[0] !== 1'b1; i++)
			@(posedge pclk);
		@(posedge pclk);
		chk("resume pulse", RSM_N, rsm_len);
		chk("full sequence", 32'h1, {31'h0, i >= RSM_N + `RHP_EOP_CYC + SYN_N - 1});
		rchk("resume done", P1, RSDC | PORT_SUSPENDED_FLAG, RSDC);
		rchk("resume event", IST, 32'h4, 32'h4);
	endtask : t_resume

	// Without power switching the power bit reads one.
	task automatic t_no_switch();
		apb(1'b1, P1, POFF);
		apb(1'b1, CTRL, 32'h18);
		rchk("always on", P1, PORT_POWER_ON_FLAG, PORT_POWER_ON_FLAG);
		chk("power en", 32'h1, {31'h0, pwr_en[0]});
	endtask : t_no_switch

	// Print the verdict and stop.
	task automatic test_done();
		if (n_mismatch == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// Main sequence.
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{susp_req, oc_req, cyc, rst_len, rsm_len, n_mismatch, n_compared} = '0;
		plug = 2'b01;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_vals();
		t_global();
		t_port_reset();
		t_disc_reset();
		t_per_port();
		t_overcurrent();
		t_resume();
		t_no_switch();
		test_done();
	end
endmodule : testbench
